// file: rtl/ssm_ctrl.v
/*
 * One channel of the supply sequence and margin controller: start
 * condition selection with on/off delay, and closed-loop margining by PWM
 * (channels 0-7) or external current DAC code (channels 8-11).
 * Assumes registers are reached by command code; voltage samples, targets
 * and the signature decoder run on clk_sys; pins pass two flip-flops.
 */
// What this block does
// - output follows start condition only after it stays stable for the delay
// - condition 00 waits for decoded start a or b chosen by bit 0
// - condition 01 starts when all masked goodness inputs are asserted
// - mask bit N+16 belongs to channel N; cleared bit excludes it
// - condition 10 starts when seen signature equals bits 11:8
// - signature code 0000 disables; 1 to 15 select signatures 1 to 15
// - unused configuration bits always read back as zero
// - non-PWM pin function takes priority; margining does not drive pin
// - channels 0 to 7 margin through their PWM at 312.5kHz
// - channels 8 to 11 margin through one external current DAC output
// - PWM and DAC outputs are high impedance while margining inactive
// - margining starts only with margin command and all supplies good
// - average four samples per 20ms, then step setting once
// - bit 15 picks slope: 0 negative, 1 positive
// - bit 14 holds the initial level with no closed-loop correction
// - initial level loads as starting PWM duty when margining begins; DAC channels start at code 0
// - overshoot on first step or saturation raises a margin fault
// - after margining with faults ignored, suspend monitoring 100ms
`timescale 1ns/100ps
`include "ssm_defines.vh"

module ssm_ctrl
#(
    parameter        CHANNEL   = 0,
    parameter [31:0] MS_CYCLES = `SSM_MS_CYCLES
)
(
    clk_sys,
    rstn,
    cmd_code,
    cmd_write,
    cmd_wdata,
    cmd_rdata,
    decoded_start_a,
    decoded_start_b,
    goodness_inputs,
    signature_seen,
    on_delay_sel,
    off_delay_sel,
    control_input_pin,
    supply_enable_out,
    margin_state,
    all_supplies_good,
    pin_is_pwm,
    ignore_faults,
    vout_sample,
    sample_strobe,
    target_high,
    target_low,
    margin_output_pin,
    margin_output_oe,
    dac_code,
    dac_output_oe,
    margin_fault,
    monitor_suspend
);
    input  wire        clk_sys;
    input  wire        rstn;
    input  wire [7:0]  cmd_code;
    input  wire        cmd_write;
    input  wire [31:0] cmd_wdata;
    output reg  [31:0] cmd_rdata;
    input  wire        decoded_start_a;
    input  wire        decoded_start_b;
    input  wire [15:0] goodness_inputs;
    input  wire [3:0]  signature_seen;
    input  wire [3:0]  on_delay_sel;
    input  wire [3:0]  off_delay_sel;
    input  wire        control_input_pin;
    output reg         supply_enable_out;
    input  wire [1:0]  margin_state;
    input  wire        all_supplies_good;
    input  wire        pin_is_pwm;
    input  wire        ignore_faults;
    input  wire [15:0] vout_sample;
    input  wire        sample_strobe;
    input  wire [15:0] target_high;
    input  wire [15:0] target_low;
    output reg         margin_output_pin;
    output reg         margin_output_oe;
    output reg  [7:0]  dac_code;
    output reg         dac_output_oe;
    output reg         margin_fault;
    output reg         monitor_suspend;

    localparam        IS_DAC  = (CHANNEL >= 8);
    localparam [1:0]  ST_IDLE = 2'h0;
    localparam [1:0]  ST_WAIT = 2'h1;
    localparam [1:0]  ST_RUN  = 2'h2;
    localparam [1:0]  ST_HOLD = 2'h3;
    localparam [24:0] MS_LAST = MS_CYCLES[24:0] - 25'h0000001;
    localparam [31:0] HOLD_FULL = `SSM_HOLDOFF_MS;
    localparam [6:0]  HOLD_LAST = HOLD_FULL[6:0];

    // delay code to milliseconds
    function [11:0] delay_ms;
        input [3:0] code;
        begin
            case (code)
                4'h0:    delay_ms = 12'd0;
                4'h1:    delay_ms = 12'd5;
                4'h2:    delay_ms = 12'd10;
                4'h3:    delay_ms = 12'd20;
                4'h4:    delay_ms = 12'd40;
                4'h5:    delay_ms = 12'd60;
                4'h6:    delay_ms = 12'd80;
                4'h7:    delay_ms = 12'd100;
                4'h8:    delay_ms = 12'd200;
                4'h9:    delay_ms = 12'd400;
                4'hA:    delay_ms = 12'd600;
                4'hB:    delay_ms = 12'd800;
                4'hC:    delay_ms = 12'd1000;
                4'hD:    delay_ms = 12'd1500;
                4'hE:    delay_ms = 12'd2000;
                default: delay_ms = 12'd4000;
            endcase
        end
    endfunction

    // one count up or down, held at the ends
    function [7:0] step_sat;
        input [7:0] level;
        input       up;
        begin
            if (up)
                step_sat = (level == `SSM_FULL_SCALE) ? level : level + 8'h01;
            else
                step_sat = (level == 8'h00) ? level : level - 8'h01;
        end
    endfunction

    reg  [15:0] margin_cfg;
    reg  [31:0] seq_cfg;
    reg         ctl_meta;
    reg         ctl_sync;
    reg  [24:0] ms_count;
    reg         ms_tick;
    reg  [11:0] dly_count;
    reg  [1:0]  state;
    reg  [7:0]  level;
    reg  [17:0] sum;
    reg  [1:0]  nsamp;
    reg         first_step;
    reg         ran_ignored;
    reg  [6:0]  hold_ms;
    reg         raw_start;
    reg  [15:0] masked;
    wire [1:0]  cond;
    wire [3:0]  match_code;
    wire [15:0] avg;
    wire [17:0] next_sum;
    wire [15:0] target;
    wire        want_up;
    wire        setting_up;
    wire        margin_req;
    wire        pwm_raw;
    wire [11:0] dly_limit;

    assign cond       = seq_cfg[`SSM_SEQ_COND_HI:`SSM_SEQ_COND_LO];
    assign match_code = seq_cfg[`SSM_SIGNATURE_MATCH_CODE_HI:`SSM_SIGNATURE_MATCH_CODE_LO];
    assign next_sum   = sum + {2'b00, vout_sample};
    assign avg        = next_sum[17:2];
    assign margin_req = (margin_state == `SSM_MARGIN_LOW) ||
                        (margin_state == `SSM_MARGIN_HIGH);
    assign target     = (margin_state == `SSM_MARGIN_HIGH) ? target_high : target_low;
    assign want_up    = (avg < target);
    // raise voltage: positive slope raises setting, negative lowers it
    assign setting_up = margin_cfg[`SSM_MRG_SLOPE_BIT] ? want_up : ~want_up;
    assign dly_limit  = raw_start ? delay_ms(on_delay_sel) : delay_ms(off_delay_sel);

    // pin input synchroniser
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl_meta <= 1'b0;
            ctl_sync <= 1'b0;
        end
        else
        begin
            ctl_meta <= control_input_pin;
            ctl_sync <= ctl_meta;
        end
    end

    // start condition select
    always @*
    begin
        masked = goodness_inputs | ~seq_cfg[`SSM_SEQ_MASK_HI:`SSM_SEQ_MASK_LO];
        case (cond)
            `SSM_COND_DECODED:
                raw_start = seq_cfg[`SSM_SEQ_CHOICE_BIT] ? decoded_start_b
                                                         : decoded_start_a;
            `SSM_COND_GOODNESS:
                raw_start = &masked;
            `SSM_COND_SIGNATURE:
                raw_start = (match_code != 4'h0) && (signature_seen == match_code);
            default:
                raw_start = 1'b0;
        endcase
        raw_start = raw_start & ctl_sync;
    end

    // register writes and reads
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            margin_cfg <= `SSM_MARGIN_RESET;
            seq_cfg    <= `SSM_SEQ_RESET;
            cmd_rdata  <= 32'h00000000;
        end
        else
        begin
            if (cmd_write && cmd_code == `SSM_CMD_MARGIN_CFG)
                margin_cfg <= cmd_wdata[15:0] & `SSM_MRG_RW_MASK;
            if (cmd_write && cmd_code == `SSM_CMD_SEQ_CFG)
                seq_cfg <= cmd_wdata & `SSM_SEQ_RW_MASK;
            case (cmd_code)
                `SSM_CMD_MARGIN_CFG: cmd_rdata <= {16'h0000, margin_cfg};
                `SSM_CMD_SEQ_CFG:    cmd_rdata <= seq_cfg;
                default:             cmd_rdata <= 32'h00000000;
            endcase
        end
    end

    // millisecond tick
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ms_count <= 25'h0000000;
            ms_tick  <= 1'b0;
        end
        else
        begin
            ms_tick  <= (ms_count == MS_LAST);
            ms_count <= (ms_count == MS_LAST) ? 25'h0000000 : ms_count + 25'h0000001;
        end
    end

    // on/off delay: a change must stand for the whole delay
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            dly_count         <= 12'h000;
            supply_enable_out <= 1'b0;
        end
        else if (raw_start == supply_enable_out)
            dly_count <= 12'h000;
        else if (dly_count >= dly_limit)
        begin
            supply_enable_out <= raw_start;
            dly_count         <= 12'h000;
        end
        else if (ms_tick)
            dly_count <= dly_count + 12'h001;
    end

    // margining engine
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state        <= ST_IDLE;
            level        <= 8'h00;
            sum          <= 18'h00000;
            nsamp        <= 2'h0;
            first_step   <= 1'b0;
            ran_ignored  <= 1'b0;
            hold_ms      <= 7'h00;
            margin_fault <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    margin_fault <= 1'b0;
                    if (margin_req)
                        state <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (!margin_req)
                        state <= ST_IDLE;
                    else if (all_supplies_good)
                    begin
                        state       <= ST_RUN;
                        level       <= IS_DAC ? 8'h00 : margin_cfg[7:0];
                        sum         <= 18'h00000;
                        nsamp       <= 2'h0;
                        first_step  <= 1'b1;
                        ran_ignored <= ignore_faults;
                    end
                end
                ST_RUN:
                begin
                    if (ignore_faults)
                        ran_ignored <= 1'b1;
                    if (!margin_req)
                    begin
                        state   <= ran_ignored ? ST_HOLD : ST_IDLE;
                        hold_ms <= 7'h00;
                    end
                    else if (margin_cfg[`SSM_MRG_OPEN_BIT])
                        level <= margin_cfg[7:0];
                    else if (sample_strobe)
                    begin
                        nsamp <= nsamp + 2'h1;
                        sum   <= (nsamp == 2'h3) ? 18'h00000 : next_sum;
                        if (nsamp == 2'h3 && avg != target)
                        begin
                            level      <= step_sat(level, setting_up);
                            first_step <= 1'b0;
                            // overshoot on the first step, or stuck at an end
                            if ((first_step && !want_up &&
                                 margin_state == `SSM_MARGIN_HIGH) ||
                                (first_step && want_up &&
                                 margin_state == `SSM_MARGIN_LOW) ||
                                (setting_up && level == `SSM_FULL_SCALE) ||
                                (!setting_up && level == 8'h00))
                                margin_fault <= 1'b1;
                        end
                        else if (nsamp == 2'h3)
                            first_step <= 1'b0;
                    end
                end
                ST_HOLD:
                begin
                    // margining is over, so its fault no longer stands
                    margin_fault <= 1'b0;
                    if (ms_tick)
                        hold_ms <= hold_ms + 7'h01;
                    if (hold_ms == HOLD_LAST)
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // fault monitoring held off after an ignored-fault margin run
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            monitor_suspend <= 1'b0;
        else
            monitor_suspend <= (state == ST_HOLD) &&
                               (hold_ms != HOLD_LAST);
    end

    ssm_pwm u_pwm
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .duty    (level),
        .pwm_out (pwm_raw)
    );

    // output drivers, high impedance when not margining
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            margin_output_pin <= 1'b0;
            margin_output_oe  <= 1'b0;
            dac_code          <= 8'h00;
            dac_output_oe     <= 1'b0;
        end
        else
        begin
            margin_output_pin <= pwm_raw;
            margin_output_oe  <= !IS_DAC && (state == ST_RUN) && pin_is_pwm;
            dac_code          <= IS_DAC ? level : 8'h00;
            dac_output_oe     <= IS_DAC && (state == ST_RUN);
        end
    end
endmodule

// file: rtl/ssm_defines.vh
/*
 * Constants for the supply sequence and margin controller: command codes,
 * field positions, reset values and timing counts.
 * Assumes a 20 MHz system clock; included by bare name.
 */
`ifndef SSM_DEFINES_VH
`define SSM_DEFINES_VH

// command codes of the two configuration registers
`define SSM_CMD_MARGIN_CFG   8'hDF
`define SSM_CMD_SEQ_CFG      8'hE8

// reset values
`define SSM_MARGIN_RESET     16'h0000
`define SSM_SEQ_RESET        32'h00000000

// sequence_start_configuration fields
`define SSM_SEQ_MASK_HI      31
`define SSM_SEQ_MASK_LO      16
`define SSM_SIGNATURE_MATCH_CODE_HI     11
`define SSM_SIGNATURE_MATCH_CODE_LO     8
`define SSM_SEQ_COND_HI      5
`define SSM_SEQ_COND_LO      4
`define SSM_SEQ_CHOICE_BIT   0
`define SSM_SEQ_RW_MASK      32'hFFFF0F31

// start condition encodings
`define SSM_COND_DECODED     2'h0
`define SSM_COND_GOODNESS    2'h1
`define SSM_COND_SIGNATURE   2'h2

// margin_configuration fields
`define SSM_MRG_SLOPE_BIT    15
`define SSM_MRG_OPEN_BIT     14
`define SSM_MRG_RW_MASK      16'hC0FF

// operating margin states
`define SSM_MARGIN_OFF       2'h0
`define SSM_MARGIN_LOW       2'h1
`define SSM_MARGIN_HIGH      2'h2

// timing
`define SSM_CLK_HZ           20000000
`define SSM_MS_CYCLES        (`SSM_CLK_HZ / 1000)
`define SSM_PWM_HZ_X10       3125000
`define SSM_PWM_PERIOD       (`SSM_CLK_HZ * 10 / `SSM_PWM_HZ_X10)
`define SSM_HOLDOFF_MS       100
`define SSM_AVG_SAMPLES      4
`define SSM_FULL_SCALE       8'hFF

`endif

// file: rtl/ssm_pwm.v
/*
 * Fixed-frequency PWM generator for margining, 64 clocks per period.
 * Assumes duty changes are taken at any time; output is a flip-flop.
 */
`timescale 1ns/100ps
`include "ssm_defines.vh"

module ssm_pwm
(
    clk_sys,
    rstn,
    duty,
    pwm_out
);
    input  wire       clk_sys;
    input  wire       rstn;
    input  wire [7:0] duty;
    output reg        pwm_out;

    localparam [31:0] LAST_FULL = `SSM_PWM_PERIOD - 1;
    localparam [5:0]  LAST      = LAST_FULL[5:0];

    reg  [5:0] phase;
    wire [7:0] phase_scaled;

    // phase scaled to the 8-bit duty range
    assign phase_scaled = {phase, 2'b00};

    // period counter and compare
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            phase   <= 6'h00;
            pwm_out <= 1'b0;
        end
        else
        begin
            phase   <= (phase == LAST) ? 6'h00 : phase + 6'h01;
            pwm_out <= (phase_scaled < duty);
        end
    end
endmodule

// file: bench/ssm_ctrl_sva.sv
/*
 * Port-level checker for one supply sequence and margin channel.
 * Assumes a single clk_sys domain and the asynchronous active-low rstn.
 */
`timescale 1ns/100ps

module ssm_ctrl_sva
#(
    parameter CHANNEL = 0
)
(
    input wire        clk_sys,
    input wire        rstn,
    input wire [7:0]  cmd_code,
    input wire [31:0] cmd_rdata,
    input wire [1:0]  margin_state,
    input wire        all_supplies_good,
    input wire        pin_is_pwm,
    input wire        sample_strobe,
    input wire        margin_output_oe,
    input wire [7:0]  dac_code,
    input wire        dac_output_oe,
    input wire        margin_fault,
    input wire        monitor_suspend
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // margin command off for three cycles
    sequence s_idle;
        (margin_state == 2'h0) [*3];
    endsequence

    // dac output enabled for three cycles
    sequence s_run;
        dac_output_oe [*3];
    endsequence

    idle_float_a: assert property (s_idle |-> !dac_output_oe && !margin_output_oe)
        else $error("margin output enabled while idle");
    good_gate_a: assert property ($rose(dac_output_oe) |-> $past(all_supplies_good) || $past(all_supplies_good, 2))
        else $error("margin output enabled before supplies good");
    pin_prio_a: assert property (!pin_is_pwm [*2] |-> !margin_output_oe)
        else $error("pwm pin driven while pin has other function");
    chan_route_a: assert property ((CHANNEL >= 8) ? !margin_output_oe : !dac_output_oe)
        else $error("margin output on wrong path for channel");
    step_one_a: assert property (s_run ##0 $changed(dac_code) |-> (dac_code == $past(dac_code) + 8'h01 && $past(dac_code) != 8'hFF) || (dac_code == $past(dac_code) - 8'h01 && $past(dac_code) != 8'h00))
        else $error("margin setting moved by other than one step");
    step_cause_a: assert property (s_run ##0 $changed(dac_code) |-> $past(sample_strobe) || $past(sample_strobe, 2) || $past(sample_strobe, 3))
        else $error("margin setting moved without a sample");
    fault_clear_a: assert property (s_idle |-> !margin_fault)
        else $error("margin fault held while idle");
    seq_zero_a: assert property (cmd_code == 8'hE8 |=> (cmd_rdata & 32'h0000F0CE) == 32'h0)
        else $error("reserved sequencing bits read nonzero");
    mrg_zero_a: assert property (cmd_code == 8'hDF |=> (cmd_rdata & 32'hFFFF3F00) == 32'h0)
        else $error("reserved margin bits read nonzero");
    unmapped_a: assert property (cmd_code != 8'hE8 && cmd_code != 8'hDF |=> cmd_rdata == 32'h0)
        else $error("unmapped code read nonzero");
    suspend_off_a: assert property ($rose(monitor_suspend) |-> margin_state == 2'h0 || $past(margin_state) == 2'h0)
        else $error("fault hold-off began while margining");
endmodule

// file: bench/ssm_supply_model.sv
/*
 * Behavioural managed supply: output voltage follows the margin level.
 * Assumes the level is the dac code; one sample strobe every 8 clocks.
 */
`timescale 1ns/100ps

module ssm_supply_model
(
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire        slope,
    input  wire [7:0]  level,
    output reg  [15:0] vout_sample,
    output reg         sample_strobe
);
    reg [2:0] phase;

    // nominal 1000 counts, four counts per level step in slope direction
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            phase <= 3'h0;
            sample_strobe <= 1'b0;
            vout_sample <= 16'h0000;
        end
        else
        begin
            phase <= phase + 3'h1;
            sample_strobe <= (phase == 3'h7);
            if (slope)
                vout_sample <= 16'h03E8 + {6'h00, level, 2'h0};
            else
                vout_sample <= 16'h03E8 - {6'h00, level, 2'h0};
        end
    end
endmodule

// file: bench/ssm_ctrl_tb.sv
/*
 * Self-checking bench for one DAC-margined channel of the controller.
 * Assumes MS_CYCLES shortened to 20 clocks; inputs change at falling edge.
 */
`timescale 1ns/100ps

module ssm_ctrl_tb;
    reg         clk_sys           = 1'b0;
    reg         rstn              = 1'b0;
    reg  [7:0]  cmd_code          = 8'h00;
    reg         cmd_write         = 1'b0;
    reg  [31:0] cmd_wdata         = 32'h0;
    reg         decoded_start_a   = 1'b0;
    reg         decoded_start_b   = 1'b0;
    reg  [15:0] goodness_inputs   = 16'h0;
    reg  [3:0]  signature_seen    = 4'h0;
    reg  [3:0]  on_delay_sel      = 4'h0;
    reg  [3:0]  off_delay_sel     = 4'h0;
    reg  [1:0]  margin_state      = 2'h0;
    reg         all_supplies_good = 1'b0;
    reg         ignore_faults     = 1'b0;
    reg         model_slope       = 1'b0;
    reg         control_input_pin = 1'b1;
    reg  [15:0] target_high       = 16'h0410;
    wire [15:0] vout_sample;
    wire        sample_strobe;
    wire [31:0] cmd_rdata;
    wire        supply_enable_out;
    wire        margin_output_pin;
    wire        margin_output_oe;
    wire [7:0]  dac_code;
    wire        dac_output_oe;
    wire        margin_fault;
    wire        monitor_suspend;
    integer     errors            = 0;
    integer     comparisons       = 0;

    // system clock, 50 ns period
    always #25 clk_sys = ~clk_sys;

    ssm_ctrl #(.CHANNEL(8), .MS_CYCLES(32'd20)) dut (.clk_sys, .rstn, .cmd_code, .cmd_write,
        .cmd_wdata, .cmd_rdata, .decoded_start_a, .decoded_start_b, .goodness_inputs,
        .signature_seen, .on_delay_sel, .off_delay_sel, .control_input_pin,
        .supply_enable_out, .margin_state, .all_supplies_good, .pin_is_pwm(1'b1),
        .ignore_faults, .vout_sample, .sample_strobe, .target_high,
        .target_low(16'h03C0), .margin_output_pin, .margin_output_oe, .dac_code,
        .dac_output_oe, .margin_fault, .monitor_suspend);

    ssm_supply_model u_model (.clk_sys, .rstn, .slope(model_slope), .level(dac_code),
        .vout_sample, .sample_strobe);

    task end_of_test;
    begin
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task cyc(input integer n);
    begin
        repeat (n) @(negedge clk_sys);
    end
    endtask

    task wr(input [7:0] code, input [31:0] data);
    begin
        cmd_code = code;
        cmd_wdata = data;
        cmd_write = 1'b1;
        cyc(1);
        cmd_write = 1'b0;
    end
    endtask

    task rd(input [7:0] code, input [31:0] exp);
    begin
        cmd_code = code;
        cyc(2);
        chk(cmd_rdata, exp);
    end
    endtask

    // reset values, reserved bits, unmapped code
    task t_regs;
    begin
        rd(8'hE8, 32'h0);
        rd(8'hDF, 32'h0);
        wr(8'hE8, 32'hFFFFFFFF);
        rd(8'hE8, 32'hFFFF0F31);
        wr(8'hDF, 32'hFFFFFFFF);
        rd(8'hDF, 32'h0000C0FF);
        wr(8'h5A, 32'hFFFFFFFF);
        rd(8'h5A, 32'h0);
        rd(8'hE8, 32'hFFFF0F31);
        wr(8'hDF, 32'h0);
    end
    endtask

    // reconfigure with supply off, then apply start inputs
    task t_start(input [31:0] cfg, input a, input b, input [15:0] g, input [3:0] s,
                 input exp);
    begin
        decoded_start_a = 1'b0;
        decoded_start_b = 1'b0;
        goodness_inputs = 16'h0;
        signature_seen = 4'h0;
        cyc(4);
        wr(8'hE8, cfg);
        decoded_start_a = a;
        decoded_start_b = b;
        goodness_inputs = g;
        signature_seen = s;
        cyc(8);
        chk(supply_enable_out, exp);
    end
    endtask

    task wait_en(input exp);
        integer i;
    begin
        i = 0;
        while (supply_enable_out !== exp && i < 80)
        begin
            cyc(1);
            i = i + 1;
        end
        chk(supply_enable_out, exp);
    end
    endtask

    // 5 ms on and off delay, 100 clocks here
    task t_delay;
    begin
        t_start(32'h0, 1'b0, 1'b0, 16'h0, 4'h0, 1'b0);
        on_delay_sel = 4'h1;
        off_delay_sel = 4'h1;
        decoded_start_a = 1'b1;
        cyc(40);
        decoded_start_a = 1'b0;
        cyc(120);
        chk(supply_enable_out, 0);
        decoded_start_a = 1'b1;
        cyc(60);
        chk(supply_enable_out, 0);
        wait_en(1'b1);
        decoded_start_a = 1'b0;
        cyc(40);
        decoded_start_a = 1'b1;
        cyc(20);
        chk(supply_enable_out, 1);
        decoded_start_a = 1'b0;
        cyc(60);
        chk(supply_enable_out, 1);
        wait_en(1'b0);
        on_delay_sel = 4'h0;
        off_delay_sel = 4'h0;
    end
    endtask

    // one margin run: gate, first step or hold, fault, release
    task t_margin(input [1:0] st, input [15:0] cfg, input ign, input [7:0] exp,
                  input expf);
    begin
        model_slope = cfg[15];
        wr(8'hDF, {16'h0, cfg});
        ignore_faults = ign;
        margin_state = st;
        cyc(6);
        chk(dac_output_oe, 0);
        all_supplies_good = 1'b1;
        cyc(3);
        chk(dac_output_oe, 1);
        chk(margin_output_oe, 0);
        cyc(40);
        chk(dac_code, exp);
        chk(margin_fault, expf);
        margin_state = 2'h0;
        all_supplies_good = 1'b0;
        ignore_faults = 1'b0;
        cyc(4);
        chk(dac_output_oe, 0);
        chk(margin_fault, 0);
        chk(monitor_suspend, ign);
        if (ign)
        begin
            cyc(1900);
            chk(monitor_suspend, 1);
            cyc(200);
            chk(monitor_suspend, 0);
        end
    end
    endtask

    // main sequence
    initial
    begin
        cyc(12);
        rstn = 1'b1;
        cyc(2);
        t_regs;
        t_start(32'h00000000, 1'b1, 1'b0, 16'h0, 4'h0, 1'b1);
        // control pin low blocks the start, high lets it through
        control_input_pin = 1'b0;
        cyc(4);
        chk(supply_enable_out, 0);
        control_input_pin = 1'b1;
        cyc(4);
        chk(supply_enable_out, 1);
        t_start(32'h00000000, 1'b0, 1'b1, 16'h0, 4'h0, 1'b0);
        t_start(32'h00000001, 1'b0, 1'b1, 16'h0, 4'h0, 1'b1);
        t_start(32'h00000001, 1'b1, 1'b0, 16'h0, 4'h0, 1'b0);
        t_start(32'h00050010, 1'b0, 1'b0, 16'h0001, 4'h0, 1'b0);
        t_start(32'h00050010, 1'b0, 1'b0, 16'h0005, 4'h0, 1'b1);
        t_start(32'h00050010, 1'b0, 1'b0, 16'h000A, 4'h0, 1'b0);
        t_start(32'h00000520, 1'b0, 1'b0, 16'h0, 4'h5, 1'b1);
        t_start(32'h00000520, 1'b0, 1'b0, 16'h0, 4'h4, 1'b0);
        t_start(32'h00000020, 1'b0, 1'b0, 16'h0, 4'h0, 1'b0);
        t_start(32'h00000F20, 1'b0, 1'b0, 16'h0, 4'hF, 1'b1);
        t_start(32'h00000030, 1'b1, 1'b1, 16'hFFFF, 4'h5, 1'b0);
        t_delay;
        t_margin(2'h2, 16'h8000, 1'b0, 8'h01, 1'b0);
        t_margin(2'h2, 16'h0000, 1'b0, 8'h00, 1'b1);
        chk(margin_output_pin, 0);
        t_margin(2'h1, 16'h0000, 1'b1, 8'h01, 1'b0);
        t_margin(2'h1, 16'h8000, 1'b0, 8'h00, 1'b1);
        // high target below nominal: first evaluation overshoots
        target_high = 16'h03D0;
        t_margin(2'h2, 16'h0000, 1'b0, 8'h01, 1'b1);
        target_high = 16'h0410;
        t_margin(2'h2, 16'h405A, 1'b0, 8'h5A, 1'b0);
        end_of_test;
    end

    // watchdog, well beyond the expected run
    initial
    begin
        #(50 * 20000);
        errors = errors + 1;
        end_of_test;
    end
endmodule

bind ssm_ctrl ssm_ctrl_sva #(.CHANNEL(CHANNEL)) u_sva (.clk_sys, .rstn, .cmd_code, .cmd_rdata,
    .margin_state, .all_supplies_good, .pin_is_pwm, .sample_strobe, .margin_output_oe,
    .dac_code, .dac_output_oe, .margin_fault, .monitor_suspend);
